// >>> core/iops_pkg.sv
// constants, types and register map of the pad power-up sequencer
// assumes one 100 MHz clock and a synchronous active-high system reset
//
// Overview of operation
// - power-on only completes once core, auxiliary and bank-4 output supplies are all good.
// - with pullup_disable low, pads get weak pull-ups from power-on until start-up ends and user mode begins.
// - with pullup_disable high, pads have no pull-ups during power-on and configuration.
// - an unconnected pullup_disable pin counts as high, so pads float by default.
// - once power is present, memory clearing starts together with global_set_reset asserted.
// - global_set_reset asynchronously forces every pad storage element low.
// - at the end of memory clearing init_status rises and the three mode pins are sampled.
// - during configuration every pad driver stays high impedance, pulls set by pullup_disable.
// - start-up releases global_three_state; assigned pads drive, unassigned ones stay off.
// - releasing global_set_reset leaves pad registers low, or high where set/reset is inverted.
// - in user mode configuration pull-ups are off and pullup_disable is ignored.
// - in user mode unused pads share one termination option; used pads get only their own.
`default_nettype none

package iops_pkg;

    // ***********************************************************
    // sequence timing (cycles of clk_i)
    // ***********************************************************
    localparam int unsigned CNT_W = 13;
    localparam int unsigned INIT_CYCLES_DEF = 64;
    localparam logic [12:0] STARTUP_GSR_LAST = 13'h0001;

    // ***********************************************************
    // register byte offsets
    // ***********************************************************
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h04;
    localparam logic [4:0] ADDR_PAD_USED = 5'h08;
    localparam logic [4:0] ADDR_PAD_PULLUP = 5'h0C;
    localparam logic [4:0] ADDR_PAD_PULLDN = 5'h10;
    localparam logic [4:0] ADDR_PAD_SRINV = 5'h14;
    localparam logic [4:0] ADDR_UNUSED_TERM = 5'h18;
    localparam logic [4:0] ADDR_PAD_DATA = 5'h1C;

    // ***********************************************************
    // field positions and reset values
    // ***********************************************************
    localparam int unsigned CTRL_CFG_DONE_BIT = 0;
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_INIT_BIT = 8;
    localparam int unsigned STAT_GTS_BIT = 9;
    localparam int unsigned STAT_GSR_BIT = 10;
    localparam int unsigned STAT_MODE_LSB = 16;
    localparam int unsigned STAT_SUPPLY_LSB = 24;
    localparam logic [31:0] PAD_MASK_RST = 32'h0000_0000;
    localparam logic [1:0] TERM_RST = 2'h0;

    // ***********************************************************
    // types
    // ***********************************************************
    typedef enum logic [4:0] {
        ST_POR = 5'h01,
        ST_INIT = 5'h02,
        ST_CFG = 5'h04,
        ST_STARTUP = 5'h08,
        ST_USER = 5'h10
    } iops_state_t;

    typedef enum logic [1:0] {
        TERM_NONE = 2'h0,
        TERM_UP = 2'h1,
        TERM_DOWN = 2'h2
    } iops_term_t;

    typedef struct packed {
        logic bank4_ok;
        logic aux_ok;
        logic core_ok;
    } iops_supply_t;

    typedef struct packed {
        logic config_mode_2;
        logic config_mode_1;
        logic config_mode_0;
    } iops_mode_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } iops_avs_req_t;

endpackage

`default_nettype wire

// >>> core/iops_pad_store.sv
// pad storage elements cleared asynchronously by the global set-reset
// assumes gsr_i comes straight from a flip-flop of the sequencer
`default_nettype none

module iops_pad_store #(
    parameter int unsigned NUM_PADS = 8
) (
    input wire logic clk_i,
    input wire logic gsr_i,
    input wire logic rel_i,
    input wire logic [NUM_PADS-1:0] srinv_i,
    input wire logic wr_i,
    input wire logic [NUM_PADS-1:0] data_i,
    output logic [NUM_PADS-1:0] q_o
);
    import iops_pkg::*;

    logic [NUM_PADS-1:0] q_q;
    logic [NUM_PADS-1:0] q_d;

    // ***********************************************************
    // next value: release preset, then software data
    // ***********************************************************
    always_comb begin
        q_d = q_q;
        if (rel_i) begin
            q_d = srinv_i;
        end else if (wr_i) begin
            q_d = data_i;
        end
    end

    // global set-reset clears without the clock
    always_ff @(posedge clk_i or posedge gsr_i) begin
        if (gsr_i) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    assign q_o = q_q;

endmodule

`default_nettype wire

// >>> core/iops_seq.sv
// power-up, configuration and user-mode sequencer for the user pads
// assumes supply monitors, straps and bus signals synchronous to clk_i
//
// Design decisions made here: the address map and register access over Avalon-MM.
`default_nettype none

module iops_seq #(
    parameter int unsigned NUM_PADS = 8,
    parameter int unsigned INIT_CYCLES = iops_pkg::INIT_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire iops_pkg::iops_supply_t supply_ok_i,
    input wire logic pullup_disable_i,
    input wire logic pullup_disable_driven_i,
    input wire iops_pkg::iops_mode_t config_mode_i,
    input wire iops_pkg::iops_avs_req_t avs_req_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic init_status_o,
    output logic global_three_state_o,
    output logic global_set_reset_o,
    output iops_pkg::iops_mode_t config_mode_o,
    output iops_pkg::iops_state_t state_o,
    output logic [NUM_PADS-1:0] pad_out_o,
    output logic [NUM_PADS-1:0] pad_oe_o,
    output logic [NUM_PADS-1:0] pad_pullup_o,
    output logic [NUM_PADS-1:0] pad_pulldown_o
);
    import iops_pkg::*;

    localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);

    // ***********************************************************
    // helper functions
    // ***********************************************************

    // merge write data into a register under byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // widen a pad mask to a bus word
    function automatic logic [31:0] pad_word(input logic [NUM_PADS-1:0] v);
        logic [31:0] r;
        r = '0;
        r[NUM_PADS-1:0] = v;
        return r;
    endfunction

    // ***********************************************************
    // state
    // ***********************************************************
    iops_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic gts_q, gts_d;
    logic gsr_q, gsr_d;
    logic init_q, init_d;
    logic rel_q, rel_d;
    iops_mode_t mode_q, mode_d;

    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [NUM_PADS-1:0] used_q, used_d;
    logic [NUM_PADS-1:0] upu_q, upu_d;
    logic [NUM_PADS-1:0] upd_q, upd_d;
    logic [NUM_PADS-1:0] srinv_q, srinv_d;
    logic [1:0] term_q, term_d;

    logic [NUM_PADS-1:0] oe_q, oe_d;
    logic [NUM_PADS-1:0] pu_q, pu_d;
    logic [NUM_PADS-1:0] pd_q, pd_d;

    logic pwr_ok;
    logic req;
    logic take;
    logic wr_take;
    logic cfg_done_wr;
    logic data_wr;
    logic eff_disable;
    logic user_mode;
    logic [31:0] status_w;
    logic [31:0] wmerge;

    // ***********************************************************
    // power and bus qualifiers
    // ***********************************************************

    // all three monitored supplies at their minimum
    assign pwr_ok = supply_ok_i.core_ok & supply_ok_i.aux_ok & supply_ok_i.bank4_ok;

    // one wait cycle, then the access completes
    assign req = avs_req_i.read | avs_req_i.write;
    assign take = req & ack_q;
    assign wr_take = take & avs_req_i.write;
    assign avs_waitrequest_o = req & ~ack_q;
    assign cfg_done_wr = wr_take & (avs_req_i.address == ADDR_CTRL)
        & avs_req_i.byteenable[0] & avs_req_i.writedata[CTRL_CFG_DONE_BIT];
    assign data_wr = wr_take & (avs_req_i.address == ADDR_PAD_DATA);
    assign wmerge = avs_req_i.writedata;

    // floating strap reads as high through its internal pull
    assign eff_disable = pullup_disable_i | ~pullup_disable_driven_i;
    assign user_mode = (state_q == ST_USER);

    // ***********************************************************
    // sequencer
    // ***********************************************************

    // next state of the power-up sequence
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        gts_d = gts_q;
        gsr_d = gsr_q;
        init_d = init_q;
        mode_d = mode_q;
        rel_d = 1'b0;
        case (state_q)
            ST_POR: begin
                gts_d = 1'b1;
                gsr_d = 1'b1;
                init_d = 1'b0;
                cnt_d = '0;
                if (pwr_ok) begin
                    state_d = ST_INIT;
                end
            end
            ST_INIT: begin
                if (cnt_q == INIT_LAST) begin
                    init_d = 1'b1;
                    mode_d = config_mode_i;
                    cnt_d = '0;
                    state_d = ST_CFG;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_CFG: begin
                if (cfg_done_wr) begin
                    gts_d = 1'b0;
                    cnt_d = '0;
                    state_d = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                if (cnt_q == STARTUP_GSR_LAST) begin
                    gsr_d = 1'b0;
                    rel_d = 1'b1;
                    state_d = ST_USER;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_USER: begin
                state_d = ST_USER;
            end
            default: begin
                state_d = ST_POR;
            end
        endcase
        // supply loss restarts the whole sequence
        if (!pwr_ok) begin
            state_d = ST_POR;
            gts_d = 1'b1;
            gsr_d = 1'b1;
            init_d = 1'b0;
            cnt_d = '0;
            rel_d = 1'b0;
        end
    end

    // sequencer registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= ST_POR;
            cnt_q <= '0;
            gts_q <= 1'b1;
            gsr_q <= 1'b1;
            init_q <= 1'b0;
            rel_q <= 1'b0;
            mode_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            gts_q <= gts_d;
            gsr_q <= gsr_d;
            init_q <= init_d;
            rel_q <= rel_d;
            mode_q <= mode_d;
        end
    end

    // ***********************************************************
    // register file
    // ***********************************************************

    // status word of the sequencer
    always_comb begin
        status_w = '0;
        status_w[STAT_STATE_LSB +: 5] = state_q;
        status_w[STAT_INIT_BIT] = init_q;
        status_w[STAT_GTS_BIT] = gts_q;
        status_w[STAT_GSR_BIT] = gsr_q;
        status_w[STAT_MODE_LSB +: 3] = mode_q;
        status_w[STAT_SUPPLY_LSB +: 3] = supply_ok_i;
    end

    // bus handshake, read mux and writable fields
    always_comb begin
        ack_d = req & ~ack_q;
        rdata_d = rdata_q;
        used_d = used_q;
        upu_d = upu_q;
        upd_d = upd_q;
        srinv_d = srinv_q;
        term_d = term_q;
        if (avs_req_i.read && !ack_q) begin
            if (avs_req_i.address == ADDR_STATUS) begin
                rdata_d = status_w;
            end else if (avs_req_i.address == ADDR_PAD_USED) begin
                rdata_d = pad_word(used_q);
            end else if (avs_req_i.address == ADDR_PAD_PULLUP) begin
                rdata_d = pad_word(upu_q);
            end else if (avs_req_i.address == ADDR_PAD_PULLDN) begin
                rdata_d = pad_word(upd_q);
            end else if (avs_req_i.address == ADDR_PAD_SRINV) begin
                rdata_d = pad_word(srinv_q);
            end else if (avs_req_i.address == ADDR_UNUSED_TERM) begin
                rdata_d = {30'h0000_0000, term_q};
            end else if (avs_req_i.address == ADDR_PAD_DATA) begin
                rdata_d = pad_word(pad_out_o);
            end else begin
                rdata_d = '0;
            end
        end
        if (wr_take) begin
            if (avs_req_i.address == ADDR_PAD_USED) begin
                used_d = NUM_PADS'(be_merge(pad_word(used_q), wmerge, avs_req_i.byteenable));
            end else if (avs_req_i.address == ADDR_PAD_PULLUP) begin
                upu_d = NUM_PADS'(be_merge(pad_word(upu_q), wmerge, avs_req_i.byteenable));
            end else if (avs_req_i.address == ADDR_PAD_PULLDN) begin
                upd_d = NUM_PADS'(be_merge(pad_word(upd_q), wmerge, avs_req_i.byteenable));
            end else if (avs_req_i.address == ADDR_PAD_SRINV) begin
                srinv_d = NUM_PADS'(be_merge(pad_word(srinv_q), wmerge, avs_req_i.byteenable));
            end else if (avs_req_i.address == ADDR_UNUSED_TERM) begin
                if (avs_req_i.byteenable[0]) begin
                    term_d = avs_req_i.writedata[1:0];
                end
            end
        end
    end

    // register file flops
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
            used_q <= NUM_PADS'(PAD_MASK_RST);
            upu_q <= NUM_PADS'(PAD_MASK_RST);
            upd_q <= NUM_PADS'(PAD_MASK_RST);
            srinv_q <= NUM_PADS'(PAD_MASK_RST);
            term_q <= TERM_RST;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            used_q <= used_d;
            upu_q <= upu_d;
            upd_q <= upd_d;
            srinv_q <= srinv_d;
            term_q <= term_d;
        end
    end

    // ***********************************************************
    // pad control
    // ***********************************************************

    // drivers, pull-ups and pull-downs per sequence phase
    always_comb begin
        oe_d = gts_q ? '0 : used_q;
        if (!user_mode) begin
            pu_d = {NUM_PADS{~eff_disable}};
            pd_d = '0;
        end else begin
            // strap ignored, configuration pulls gone
            pu_d = (used_q & upu_q)
                | (~used_q & {NUM_PADS{term_q == TERM_UP}});
            pd_d = (used_q & upd_q)
                | (~used_q & {NUM_PADS{term_q == TERM_DOWN}});
        end
    end

    // pad control flops
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            oe_q <= '0;
            pu_q <= '0;
            pd_q <= '0;
        end else begin
            oe_q <= oe_d;
            pu_q <= pu_d;
            pd_q <= pd_d;
        end
    end

    // pad storage under the global set-reset
    iops_pad_store #(
        .NUM_PADS(NUM_PADS)
    ) u_store (
        .clk_i(clk_i),
        .gsr_i(gsr_q),
        .rel_i(rel_q),
        .srinv_i(srinv_q),
        .wr_i(data_wr),
        .data_i(NUM_PADS'(avs_req_i.writedata)),
        .q_o(pad_out_o)
    );

    // ***********************************************************
    // outputs
    // ***********************************************************
    assign avs_readdata_o = rdata_q;
    assign init_status_o = init_q;
    assign global_three_state_o = gts_q;
    assign global_set_reset_o = gsr_q;
    assign config_mode_o = mode_q;
    assign state_o = state_q;
    assign pad_oe_o = oe_q;
    assign pad_pullup_o = pu_q;
    assign pad_pulldown_o = pd_q;

endmodule

`default_nettype wire

// >>> bench/iops_seq_sva.sv
// assertions on the ports of the pad power-up sequencer
// assumes one clock and the synchronous active-high reset of iops_seq
`default_nettype none

module iops_seq_sva #(
    parameter int unsigned NUM_PADS = 8,
    parameter int unsigned INIT_CYCLES = 64
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire iops_pkg::iops_supply_t supply_ok_i,
    input wire logic pullup_disable_i,
    input wire logic pullup_disable_driven_i,
    input wire iops_pkg::iops_mode_t config_mode_i,
    input wire iops_pkg::iops_avs_req_t avs_req_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic init_status_o,
    input wire logic global_three_state_o,
    input wire logic global_set_reset_o,
    input wire iops_pkg::iops_mode_t config_mode_o,
    input wire iops_pkg::iops_state_t state_o,
    input wire logic [NUM_PADS-1:0] pad_out_o,
    input wire logic [NUM_PADS-1:0] pad_oe_o,
    input wire logic [NUM_PADS-1:0] pad_pullup_o,
    input wire logic [NUM_PADS-1:0] pad_pulldown_o
);
    import iops_pkg::*;
    // ********
    // helper logic
    // ********
    logic eff_dis;
    logic pwr_ok;
    logic [15:0] cnt_d;
    logic [15:0] cnt_q;
    // floating strap counts as high
    assign eff_dis = pullup_disable_i | ~pullup_disable_driven_i;
    assign pwr_ok = &supply_ok_i;
    // cycles spent clearing memory
    always_comb begin
        cnt_d = (state_o == ST_INIT) ? cnt_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk_i) begin
        cnt_q <= cnt_d;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // ********
    // properties
    // ********
    property p_por;
        !pwr_ok |=> state_o == ST_POR && global_three_state_o && !init_status_o;
    endproperty
    a_por: assert property (p_por) else $error("no restart on supply loss");
    property p_clr;
        state_o == ST_INIT |-> global_set_reset_o && global_three_state_o && !init_status_o;
    endproperty
    a_clr: assert property (p_clr) else $error("set-reset low while clearing");
    property p_pull;
        state_o == ST_CFG && $past(state_o) == ST_CFG
            |-> pad_pullup_o == {NUM_PADS{!$past(eff_dis)}} && pad_pulldown_o == '0;
    endproperty
    a_pull: assert property (p_pull) else $error("wrong pulls in configuration");
    property p_hiz;
        global_three_state_o && $past(global_three_state_o) |-> pad_oe_o == '0;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pad driven while three-stated");
    property p_mode;
        $rose(init_status_o) |-> $past(state_o) == ST_INIT && state_o == ST_CFG
            && config_mode_o == $past(config_mode_i);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not sampled at init end");
    property p_len;
        state_o == ST_CFG && $past(state_o) == ST_INIT |-> cnt_q == 16'(INIT_CYCLES);
    endproperty
    a_len: assert property (p_len) else $error("wrong clearing length");
    property p_gts;
        $fell(global_three_state_o) |-> state_o == ST_STARTUP && $past(state_o) == ST_CFG;
    endproperty
    a_gts: assert property (p_gts) else $error("three-state released out of order");
    property p_start;
        state_o == ST_STARTUP && $past(state_o) == ST_CFG && pwr_ok ##1 pwr_ok
            |-> global_set_reset_o ##1 state_o == ST_USER && !global_set_reset_o;
    endproperty
    a_start: assert property (p_start) else $error("bad start-up sequence");
    property p_store;
        global_set_reset_o |-> pad_out_o == '0;
    endproperty
    a_store: assert property (p_store) else $error("pad storage not cleared");
    // main scenarios reached
    c_init: cover property ($rose(init_status_o));
    c_user: cover property (state_o == ST_STARTUP ##2 state_o == ST_USER);
    c_loss: cover property (state_o == ST_USER ##1 state_o == ST_POR);
endmodule

bind iops_seq iops_seq_sva #(.NUM_PADS(NUM_PADS), .INIT_CYCLES(INIT_CYCLES)) chk_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok_i),
    .pullup_disable_i(pullup_disable_i), .pullup_disable_driven_i(pullup_disable_driven_i),
    .config_mode_i(config_mode_i), .avs_req_i(avs_req_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .init_status_o(init_status_o),
    .global_three_state_o(global_three_state_o), .global_set_reset_o(global_set_reset_o),
    .config_mode_o(config_mode_o), .state_o(state_o), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o), .pad_pulldown_o(pad_pulldown_o)
);

`default_nettype wire

// >>> bench/iops_board.sv
// board model: supply ramp in four orders, mode straps, hold-off strap
// assumes commands from the bench change right after a rising edge
`default_nettype none

module iops_board (
    input wire logic clk_i,
    input wire logic pwr_on_i,
    input wire logic [1:0] rot_i,
    input wire logic [2:0] drop_i,
    input wire logic strap_hi_i,
    input wire logic strap_float_i,
    input wire iops_pkg::iops_mode_t mode_i,
    output iops_pkg::iops_supply_t supply_ok_o,
    output logic pullup_disable_o,
    output logic pullup_disable_driven_o,
    output iops_pkg::iops_mode_t config_mode_o
);
    import iops_pkg::*;
    logic [3:0] ramp_q = 4'h0;
    logic flt_q = 1'b0;
    logic [2:0] up;
    logic [2:0] rail;
    // one rail comes good every three cycles
    always @(posedge clk_i) begin
        ramp_q <= pwr_on_i ? ramp_q + {3'h0, ramp_q != 4'hF} : 4'h0;
        flt_q <= ~flt_q;
    end
    // rail order picked by rot_i
    always_comb begin
        up = {ramp_q >= 4'h9, ramp_q >= 4'h6, ramp_q >= 4'h3};
        case (rot_i)
            2'h1: rail = {up[1:0], up[2]};
            2'h2: rail = {up[0], up[2:1]};
            2'h3: rail = {up[0], up[1], up[2]};
            default: rail = up;
        endcase
    end
    assign supply_ok_o = iops_supply_t'(rail & ~drop_i); // single rails lost on command
    // a floating strap shows no stable level
    assign pullup_disable_o = strap_float_i ? flt_q : strap_hi_i;
    assign pullup_disable_driven_o = ~strap_float_i;
    assign config_mode_o = mode_i;
endmodule

`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the pad power-up sequencer
// assumes iops_seq, the board model and the bound checker
`default_nettype none

`define CHK(a, b) begin \
    n_tests++; \
    if ((a) !== (b)) begin \
        errors++; \
        $display("wrong value at %0t: %h vs %h", $time, (a), (b)); \
    end \
end

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import iops_pkg::*;
    localparam int unsigned NP = 8;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    iops_avs_req_t req = '0;
    logic pwr_on = 1'b0;
    logic [1:0] rot = 2'h0;
    logic [2:0] drop = 3'h0;
    logic strap_hi = 1'b0;
    logic strap_float = 1'b0;
    iops_mode_t mode = '0;
    iops_supply_t supply_ok_i;
    logic pullup_disable_i, pullup_disable_driven_i;
    iops_mode_t config_mode_i, config_mode_o;
    logic [31:0] avs_readdata_o, rdata;
    logic avs_waitrequest_o, init_status_o, global_three_state_o, global_set_reset_o;
    iops_state_t state_o;
    logic [NP-1:0] pad_out_o, pad_oe_o, pad_pullup_o, pad_pulldown_o;
    int errors = 0;
    int n_tests = 0;
    int seed = 15;
    int cyc = 0;
    // ********
    // design and board
    // ********
    iops_seq #(.NUM_PADS(NP), .INIT_CYCLES(4)) dut_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok_i),
        .pullup_disable_i(pullup_disable_i), .pullup_disable_driven_i(pullup_disable_driven_i),
        .config_mode_i(config_mode_i), .avs_req_i(req), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .init_status_o(init_status_o),
        .global_three_state_o(global_three_state_o), .global_set_reset_o(global_set_reset_o),
        .config_mode_o(config_mode_o), .state_o(state_o), .pad_out_o(pad_out_o),
        .pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o), .pad_pulldown_o(pad_pulldown_o)
    );
    iops_board brd_u (
        .clk_i(clk_i), .pwr_on_i(pwr_on), .rot_i(rot), .drop_i(drop),
        .strap_hi_i(strap_hi), .strap_float_i(strap_float), .mode_i(mode),
        .supply_ok_o(supply_ok_i), .pullup_disable_o(pullup_disable_i),
        .pullup_disable_driven_o(pullup_disable_driven_i), .config_mode_o(config_mode_i)
    );
    // clock and hang guard
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            close_out();
        end
    end
    // ********
    // tasks and expectations
    // ********
    task automatic close_out();
        if (errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one bus access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        req <= {~wr, wr, a, 4'hF, d};
        // waitrequest and readdata as they stand at this edge
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        rdata = avs_readdata_o;
        req <= '0;
        @(posedge clk_i);
    endtask
    task automatic wait_st(input iops_state_t s);
        int k;
        k = 0;
        while (state_o !== s && k < 200) begin
            @(posedge clk_i);
            k++;
        end
        `CHK(state_o, s)
    endtask
    function automatic logic [NP-1:0] exp_pull(input logic [NP-1:0] used,
                                               input logic [NP-1:0] own, input logic on);
        return (used & own) | (~used & {NP{on}});
    endfunction
    function automatic logic [31:0] exp_status(input iops_mode_t m);
        return {5'h00, 3'h7, 5'h00, m, 5'h00, 3'h1, 3'h0, 5'h10};
    endfunction
    // full power-up with every strap, order and termination case
    task automatic run_seq(input int i);
        logic [NP-1:0] used, pu, pd, srinv;
        used = NP'($random(seed));
        pu = NP'($random(seed));
        pd = NP'($random(seed));
        srinv = NP'($random(seed));
        strap_hi <= i[0];
        strap_float <= (i == 2);
        mode <= iops_mode_t'($random(seed));
        rot <= 2'(i);
        pwr_on <= 1'b1;
        wait_st(ST_INIT);
        `CHK(global_set_reset_o, 1'b1)
        wait_st(ST_CFG);
        `CHK(init_status_o, 1'b1)
        `CHK(config_mode_o, mode)
        `CHK(pad_pullup_o, {NP{~(strap_hi | strap_float)}})
        bus(1'b1, ADDR_PAD_USED, 32'(used));
        bus(1'b1, ADDR_PAD_PULLUP, 32'(pu));
        bus(1'b1, ADDR_PAD_PULLDN, 32'(pd));
        bus(1'b1, ADDR_PAD_SRINV, 32'(srinv));
        bus(1'b1, ADDR_UNUSED_TERM, 32'(i));
        bus(1'b0, 5'h1A, 32'h0000_0000);
        `CHK(rdata, 32'h0000_0000)
        `CHK(pad_oe_o, '0)
        bus(1'b1, ADDR_CTRL, 32'h0000_0001);
        wait_st(ST_USER);
        `CHK(global_three_state_o, 1'b0)
        repeat (2) @(posedge clk_i);
        `CHK(pad_oe_o, used)
        `CHK(pad_out_o, srinv)
        `CHK(pad_pulldown_o, exp_pull(used, pd, i == 2))
        strap_hi <= ~strap_hi;
        strap_float <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK(pad_pullup_o, exp_pull(used, pu, i == 1))
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK(rdata, exp_status(mode))
        pd = NP'($random(seed)) | 8'h01;
        bus(1'b1, ADDR_PAD_DATA, 32'(pd));
        `CHK(pad_out_o, pd)
        drop <= 3'(1 << (i % 3));
        wait_st(ST_POR);
        `CHK(pad_out_o, '0)
        `CHK(init_status_o, 1'b0)
        pwr_on <= 1'b0;
        drop <= 3'h0;
        repeat (4) @(posedge clk_i);
    endtask
    // ********
    // main sequence
    // ********
    initial begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            run_seq(i);
        end
        close_out();
    end
endmodule

`default_nettype wire
